// [hdl/csb_pkg.sv]
package csb_pkg;

  // ----------------------------------------------------------------
  // Widths and base width codes
  // ----------------------------------------------------------------
  localparam int          MACHINE_NATIVE_WIDTH = 64;
  localparam logic [1:0]  WCODE_32             = 2'h1;
  localparam logic [1:0]  WCODE_64             = 2'h2;
  localparam logic [1:0]  WCODE_RSVD           = 2'h3;
  // Read-only base width code of this hart
  localparam logic [1:0]  BASE_WIDTH_CODE      = WCODE_64;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_ISA         = 12'h301;
  localparam logic [11:0] ADDR_WIDTH_CTRL  = 12'h7c0;
  localparam logic [11:0] ADDR_EXT_CTRL    = 12'h7c1;
  localparam logic [11:0] ADDR_SUP_SCRATCH = 12'h140;
  localparam logic [11:0] ADDR_EVT_CNT     = 12'h540;
  localparam logic [11:0] ADDR_EVT_CNT_HI  = 12'h5c0;

  // ----------------------------------------------------------------
  // Extension bit positions
  // ----------------------------------------------------------------
  localparam int EXT_C = 2;
  localparam int EXT_D = 3;
  localparam int EXT_E = 4;
  localparam int EXT_F = 5;
  localparam int EXT_I = 8;
  localparam int EXT_S = 18;
  localparam int EXT_U = 20;

  // Implemented letters: A C D E F I M S U
  localparam logic [25:0] ISA_SUPPORTED = 26'h014113d;
  // Letters software may change: C D F I M S U
  localparam logic [25:0] ISA_WRITABLE  = 26'h014112c;
  // Maximal set, I chosen over E
  localparam logic [25:0] ISA_RESET     = 26'h014112d;

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  localparam int          FP_MODE_LSB     = 0;
  localparam int          SUPW_VIEW_LSB   = 4;
  localparam int          SUP_CODE_LSB    = 0;
  localparam int          USER_CODE_LSB   = 2;
  localparam logic [1:0]  FP_MODE_RESET   = 2'h0;
  localparam logic [1:0]  WIDTH_RESET     = WCODE_64;
  localparam logic [63:0] SCRATCH_RO_MASK = 64'h0000_0000_0000_0003;
  localparam logic [63:0] EVT_CNT_RESET   = 64'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PRIV_U = 2'b00,
    PRIV_S = 2'b01,
    PRIV_M = 2'b11
  } csb_priv_e;

  typedef enum logic [1:0] {
    OP_READ  = 2'b00,
    OP_WRITE = 2'b01,
    OP_SET   = 2'b10,
    OP_CLEAR = 2'b11
  } csb_op_e;

  typedef struct packed {
    logic        valid;
    csb_op_e     op;
    logic [11:0] addr;
    logic [63:0] wdata;
  } csb_req_s;

  typedef struct packed {
    logic        valid;
    logic        illegal;
    logic [63:0] rdata;
  } csb_rsp_s;

endpackage : csb_pkg

// [hdl/csb_width_adapt.sv]
`timescale 1ns/1ps
module csb_width_adapt (
  // Previous-width contents
  input  wire logic [63:0] old_value,
  input  wire logic [63:0] ro_mask,
  // New width code
  input  wire logic [1:0]  new_code,
  // Contents at the new width
  output logic      [63:0] new_value
);

  logic [63:0] tmp;

  always_comb begin
    // Read-only bits never carry over
    tmp = old_value & ~ro_mask;
    if (new_code == csb_pkg::WCODE_32) begin
      new_value = {32'h0, tmp[31:0]};
    end else begin
      new_value = tmp;
    end
  end

endmodule : csb_width_adapt

// [hdl/csb_isa_legalize.sv]
`timescale 1ns/1ps
module csb_isa_legalize (
  // Current and written extension sets
  input  wire logic [25:0] cur_ext,
  input  wire logic [25:0] wr_ext,
  // Bit 1 of the address of the instruction after the write
  input  wire logic        next_pc_bit1,
  // Legal result
  output logic      [25:0] next_ext,
  output logic             suppressed
);

  logic [25:0] v;

  always_comb begin
    v = (wr_ext & csb_pkg::ISA_WRITABLE) | (cur_ext & ~csb_pkg::ISA_WRITABLE);
    // (R22) Dependent letter cannot outlive the letter it builds on
    if (v[csb_pkg::EXT_D] && !v[csb_pkg::EXT_F]) begin
      v[csb_pkg::EXT_D] = 1'b0;
      v[csb_pkg::EXT_F] = 1'b0;
    end
    if (v[csb_pkg::EXT_S] && !v[csb_pkg::EXT_U]) begin
      v[csb_pkg::EXT_S] = 1'b0;
      v[csb_pkg::EXT_U] = 1'b0;
    end
    // (R16) (R21) E is read-only, the inverse of I
    v[csb_pkg::EXT_E] = ~v[csb_pkg::EXT_I];
    // (R20) Reserved letters read zero
    v = v & csb_pkg::ISA_SUPPORTED;
    // Dropping C raises alignment; a misaligned next fetch vetoes it
    suppressed = cur_ext[csb_pkg::EXT_C] && !v[csb_pkg::EXT_C] && next_pc_bit1;
    next_ext   = suppressed ? cur_ext : v;
  end

endmodule : csb_isa_legalize

// [hdl/csb_csr_bank.sv]
//
// Functional notes
// (R01) Controlling write forces dependent field to a legal value at once.
// (R02) Alias field turning writable shows its aliased field's value.
// (R03) Forced field change fires none of that register's write effects.
// (R04) Implicit reads return what a privileged explicit read returns.
// (R05) Width change zeroes read-only bits then truncates or zero-extends.
// (R06) Width change is neither read nor write; no side effects.
// (R07) Narrow access to wide register touches only its low bits.
// (R08) High-half register aliases upper 32 bits of 64-bit counter.
// (R09) High-half register legal only at width 32; illegal at 64.
// (R10) Hart enters machine mode first after reset.
// (R11) Machine mode may access every lower-privilege register.
// (R12) ISA register is always readable; here explicit access is legal only in machine mode.
// (R13) Base width code is read-only: 1 is 32, 2 is 64.
// (R14) ISA register spans machine width; lower modes never wider.
// (R15) One presence bit per letter, bit 0 A to bit 25 Z.
// (R16) I set for full integer base, E for reduced base.
// (R17) Extensions field is write-any, read-legal with writable bits.
// (R18) Reset shows maximal extension set, I preferred over E.
// (R19) Cleared extension bit reverts its instructions and registers.
// (R20) Reserved extension bits read zero.
// (R21) E bit read-only and always the inverse of I.
// (R22) Enabling a letter while disabling its prerequisite clears both.
// (R23) Write raising alignment with misaligned next address is dropped.
// (R24) Illegal values written never trap; reads stay legal, deterministic.
//
`timescale 1ns/1ps
module csb_csr_bank (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Register access from the pipeline
  input  wire csb_pkg::csb_req_s    req,
  output csb_pkg::csb_rsp_s         rsp,
  input  wire logic [63:0]          next_pc_addr,
  // Privilege change from the pipeline
  input  wire logic                 mode_load,
  input  wire csb_pkg::csb_priv_e   mode_value,
  // Implicit read port
  input  wire logic [11:0]          implicit_addr,
  output logic      [63:0]          implicit_rdata,
  // Hart state for the pipeline
  output csb_pkg::csb_priv_e        priv_mode,
  output logic      [25:0]          ext_enabled,
  output logic                      instruction_alignment_width_16,
  output logic                      narrow_width,
  output logic                      ctrl_write_pulse
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [25:0]        isa_ext;
  logic [1:0]         sup_code;
  logic [1:0]         user_code;
  logic [1:0]         fp_mode;
  logic [63:0]        sup_scratch;
  logic [63:0]        evt_cnt;
  csb_pkg::csb_priv_e priv;

  // ----------------------------------------------------------------
  // Read view
  // ----------------------------------------------------------------
  // Returns {hit, value} at full width
  function automatic logic [64:0] csr_view(input logic [11:0] a);
    logic [1:0] supw_view;
    supw_view = isa_ext[csb_pkg::EXT_S] ? sup_code : 2'h0;
    // (R12) Always hits; explicit access still needs machine mode
    if (a == csb_pkg::ADDR_ISA) begin
      // (R13) Fixed width code
      // (R15) Letter bits 25:0, A at bit 0
      return {1'b1, csb_pkg::BASE_WIDTH_CODE, 36'h0, isa_ext};
    end else if (a == csb_pkg::ADDR_WIDTH_CTRL) begin
      return {1'b1, 60'h0, user_code, sup_code};
    end else if (a == csb_pkg::ADDR_EXT_CTRL) begin
      // (R02) Alias reads its target
      return {1'b1, 58'h0, supw_view, 2'h0, fp_mode};
    end else if (a == csb_pkg::ADDR_SUP_SCRATCH) begin
      return {1'b1, sup_scratch};
    end else if (a == csb_pkg::ADDR_EVT_CNT) begin
      return {1'b1, evt_cnt};
    end else if (a == csb_pkg::ADDR_EVT_CNT_HI) begin
      // (R08) Upper half alias
      return {1'b1, 32'h0, evt_cnt[63:32]};
    end else begin
      return 65'h0;
    end
  endfunction : csr_view

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  logic        xlen32;
  logic [64:0] view;
  logic        legal;
  logic        is_write;
  logic [63:0] op_val;
  logic [63:0] wval;
  logic        wr_ok;

  always_comb begin
    // (R14) Lower modes may run narrower than machine width
    xlen32 = (priv == csb_pkg::PRIV_S && sup_code == csb_pkg::WCODE_32) ||
             (priv == csb_pkg::PRIV_U && user_code == csb_pkg::WCODE_32);
    view     = csr_view(req.addr);
    is_write = (req.op != csb_pkg::OP_READ);
    // (R11) Machine level reaches everything below it
    legal    = view[64] && (req.addr[9:8] <= priv);
    // (R09) High half only at width 32
    if (req.addr == csb_pkg::ADDR_EVT_CNT_HI && !xlen32) begin
      legal = 1'b0;
    end
    if (req.op == csb_pkg::OP_SET) begin
      op_val = view[63:0] | req.wdata;
    end else if (req.op == csb_pkg::OP_CLEAR) begin
      op_val = view[63:0] & ~req.wdata;
    end else begin
      op_val = req.wdata;
    end
    // (R07) Upper bits kept on narrow write
    wval  = xlen32 ? {view[63:32], op_val[31:0]} : op_val;
    wr_ok = req.valid && legal && is_write;
  end

  logic wr_isa;
  logic wr_width;
  logic wr_ext;
  logic wr_scr;
  logic wr_cnt;
  logic wr_cnt_hi;

  always_comb begin
    wr_isa    = wr_ok && req.addr == csb_pkg::ADDR_ISA;
    wr_width  = wr_ok && req.addr == csb_pkg::ADDR_WIDTH_CTRL;
    wr_ext    = wr_ok && req.addr == csb_pkg::ADDR_EXT_CTRL;
    wr_scr    = wr_ok && req.addr == csb_pkg::ADDR_SUP_SCRATCH;
    wr_cnt    = wr_ok && req.addr == csb_pkg::ADDR_EVT_CNT;
    wr_cnt_hi = wr_ok && req.addr == csb_pkg::ADDR_EVT_CNT_HI;
  end

  // ----------------------------------------------------------------
  // Extensions field
  // ----------------------------------------------------------------
  logic [25:0] next_isa_ext;
  logic        isa_suppressed;

  // (R17) Write-any, read-legal legalizer
  csb_isa_legalize u_isa_legalize (
    .cur_ext      (isa_ext),
    .wr_ext       (wval[25:0]),
    .next_pc_bit1 (next_pc_addr[1]),
    .next_ext     (next_isa_ext),
    .suppressed   (isa_suppressed)
  );

  // (R18) Maximal set at reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      isa_ext <= csb_pkg::ISA_RESET;
    end else if (wr_isa) begin
      // (R23) Legalizer keeps old value on misaligned veto
      isa_ext <= next_isa_ext;
    end
  end

  // ----------------------------------------------------------------
  // Width control and alias
  // ----------------------------------------------------------------
  localparam int SUP_LSB_HI = csb_pkg::SUP_CODE_LSB + 1;

  logic [1:0] wr_sup_code;
  logic       sup_code_we;
  logic [1:0] next_sup_code;

  always_comb begin
    wr_sup_code = wr_width ? wval[SUP_LSB_HI:csb_pkg::SUP_CODE_LSB]
                           : wval[csb_pkg::SUPW_VIEW_LSB+1:csb_pkg::SUPW_VIEW_LSB];
    // (R02) Alias writes land in the aliased field when S is on
    sup_code_we = wr_width || (wr_ext && isa_ext[csb_pkg::EXT_S]);
    // (R24) Unsupported codes are ignored, never trapped
    if (sup_code_we && (wr_sup_code == csb_pkg::WCODE_32 ||
                        wr_sup_code == csb_pkg::WCODE_64)) begin
      next_sup_code = wr_sup_code;
    end else begin
      next_sup_code = sup_code;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sup_code  <= csb_pkg::WIDTH_RESET;
      user_code <= csb_pkg::WIDTH_RESET;
    end else begin
      sup_code <= next_sup_code;
      if (wr_width && (wval[csb_pkg::USER_CODE_LSB+1:csb_pkg::USER_CODE_LSB] == csb_pkg::WCODE_32 ||
                       wval[csb_pkg::USER_CODE_LSB+1:csb_pkg::USER_CODE_LSB] == csb_pkg::WCODE_64)) begin
        user_code <= wval[csb_pkg::USER_CODE_LSB+1:csb_pkg::USER_CODE_LSB];
      end
    end
  end

  // ----------------------------------------------------------------
  // Dependent floating-point field
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fp_mode <= csb_pkg::FP_MODE_RESET;
    end else if (wr_isa && next_isa_ext[csb_pkg::EXT_F] != isa_ext[csb_pkg::EXT_F]) begin
      // (R01) Legal set changed: take a legal value now
      fp_mode <= csb_pkg::FP_MODE_RESET;
    end else if (wr_ext && isa_ext[csb_pkg::EXT_F]) begin
      fp_mode <= wval[csb_pkg::FP_MODE_LSB+1:csb_pkg::FP_MODE_LSB];
    end
  end

  // ----------------------------------------------------------------
  // Width-modulated scratch
  // ----------------------------------------------------------------
  logic [63:0] scratch_adapted;

  // (R05) Carry writable bits to the new width
  csb_width_adapt u_width_adapt (
    .old_value (sup_scratch),
    .ro_mask   (csb_pkg::SCRATCH_RO_MASK),
    .new_code  (next_sup_code),
    .new_value (scratch_adapted)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sup_scratch <= 64'h0;
    end else if (wr_scr) begin
      sup_scratch <= wval & ~csb_pkg::SCRATCH_RO_MASK;
    end else if (next_sup_code != sup_code) begin
      // (R06) Silent width change
      sup_scratch <= scratch_adapted;
    end
  end

  // ----------------------------------------------------------------
  // Event counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_cnt <= csb_pkg::EVT_CNT_RESET;
    end else if (wr_cnt) begin
      // (R07) Narrow write keeps upper half
      evt_cnt <= wval;
    end else if (wr_cnt_hi) begin
      // (R08) Write through the high alias
      evt_cnt <= {op_val[31:0], evt_cnt[31:0]};
    end else begin
      evt_cnt <= evt_cnt + 64'h1;
    end
  end

  // ----------------------------------------------------------------
  // Privilege
  // ----------------------------------------------------------------
  // (R10) Machine mode out of reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      priv <= csb_pkg::PRIV_M;
    end else if (mode_load) begin
      // (R19) Modes whose letter is cleared are not entered
      if (mode_value == csb_pkg::PRIV_M ||
          (mode_value == csb_pkg::PRIV_S && isa_ext[csb_pkg::EXT_S]) ||
          (mode_value == csb_pkg::PRIV_U && isa_ext[csb_pkg::EXT_U])) begin
        priv <= mode_value;
      end
    end
  end

  // ----------------------------------------------------------------
  // Responses and outputs
  // ----------------------------------------------------------------
  logic [64:0] imp_view;

  always_comb begin
    imp_view = csr_view(implicit_addr);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp <= '0;
    end else begin
      rsp.valid   <= req.valid;
      rsp.illegal <= req.valid && !legal;
      // (R07) Narrow read returns low bits only
      rsp.rdata   <= (req.valid && legal) ?
                     (xlen32 ? {32'h0, view[31:0]} : view[63:0]) : 64'h0;
    end
  end

  // (R04) Implicit read uses the full-privilege view
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      implicit_rdata <= 64'h0;
    end else begin
      implicit_rdata <= imp_view[63:0];
    end
  end

  // (R03) Only explicit writes raise the effect pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_write_pulse <= 1'b0;
    end else begin
      ctrl_write_pulse <= wr_scr || wr_ext;
    end
  end

  // (R19) Pipeline sees live extension set and alignment
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      priv_mode    <= csb_pkg::PRIV_M;
      ext_enabled  <= csb_pkg::ISA_RESET;
      instruction_alignment_width_16    <= csb_pkg::ISA_RESET[csb_pkg::EXT_C];
      narrow_width <= 1'b0;
    end else begin
      priv_mode    <= priv;
      ext_enabled  <= isa_ext;
      instruction_alignment_width_16    <= isa_ext[csb_pkg::EXT_C];
      narrow_width <= xlen32;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // (R21) E inverts I
  chk_e_inverts_i: assert property (isa_ext[csb_pkg::EXT_E] == !isa_ext[csb_pkg::EXT_I]) // (R21)
    else $error("E bit does not invert I bit");

  // (R20) Reserved bits zero
  chk_reserved_zero: assert property ((isa_ext & ~csb_pkg::ISA_SUPPORTED) == 26'h0) // (R20)
    else $error("Reserved extension bit set");

  // (R22) Dependency pairs
  chk_dep_pairs: assert property (!(isa_ext[csb_pkg::EXT_D] && !isa_ext[csb_pkg::EXT_F]) && !(isa_ext[csb_pkg::EXT_S] && !isa_ext[csb_pkg::EXT_U])) // (R22)
    else $error("Dependent extension enabled without its base");

  // (R09) High half trap at width 64
  chk_hi_illegal: assert property (req.valid && req.addr == csb_pkg::ADDR_EVT_CNT_HI && !xlen32 |=> rsp.valid && rsp.illegal) // (R09)
    else $error("High half reachable at width 64");

  // (R01) Field legal when F clear
  chk_fp_forced: assert property (!isa_ext[csb_pkg::EXT_F] |-> fp_mode == 2'h0) // (R01)
    else $error("Floating field not legal while F is off");

  // (R03) Pulse only after explicit write
  chk_pulse_cause: assert property (ctrl_write_pulse |-> $past(wr_scr || wr_ext)) // (R03)
    else $error("Side effect without explicit write");

  // (R07) Narrow write keeps upper half
  chk_wide_upper: assert property (wr_cnt && xlen32 |=> evt_cnt[63:32] == $past(evt_cnt[63:32])) // (R07)
    else $error("Narrow write changed upper half");

  // (R23) Misaligned veto
  chk_align_veto: assert property (wr_isa && isa_ext[csb_pkg::EXT_C] && !wval[csb_pkg::EXT_C] && next_pc_addr[1] |=> $stable(isa_ext)) // (R23)
    else $error("Alignment-raising write not suppressed");

  // (R24) ISA writes never trap in machine mode
  chk_isa_no_trap: assert property (req.valid && req.addr == csb_pkg::ADDR_ISA && priv == csb_pkg::PRIV_M |=> !rsp.illegal) // (R24)
    else $error("ISA register access trapped");

endmodule : csb_csr_bank

// [testbench/csb_pipe_model.sv]
`timescale 1ns/1ps
module csb_pipe_model (
  // Clock
  input  wire logic              clk,
  // Requests and answers
  output csb_pkg::csb_req_s      req,
  output logic [63:0]            next_pc_addr,
  input  wire csb_pkg::csb_rsp_s rsp,
  // Write side effects seen
  input  wire logic              ctrl_write_pulse,
  output int                     n_pulse
);
  // ----------------------------------------------
  // One access at a time, answer one cycle later
  // ----------------------------------------------
  initial begin
    req = '0;
    next_pc_addr = 64'h0;
    n_pulse = 0;
  end

  always @(posedge clk) if (ctrl_write_pulse === 1'b1) n_pulse <= n_pulse + 1;

  task automatic access(input csb_pkg::csb_op_e op, input logic [11:0] a,
                        input logic [63:0] d, input logic pc1,
                        output csb_pkg::csb_rsp_s r);
    req.op = op;
    req.addr = a;
    req.wdata = d;
    req.valid = 1'b1;
    next_pc_addr = {62'h0, pc1, 1'b0};
    @(posedge clk);
    #1;
    r = rsp;
    // Released lines flip so a stale request never looks current
    req.valid = 1'b0;
    req.op = csb_pkg::csb_op_e'(~op);
    req.addr = ~a;
    req.wdata = ~d;
    next_pc_addr = ~next_pc_addr;
    // Idle cycle keeps each line to one change per time step
    @(posedge clk);
    #1;
  endtask : access
endmodule : csb_pipe_model

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------
  // Bench state
  // ----------------------------------------------
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               mode_load = 1'b0;
  csb_pkg::csb_priv_e mode_value = csb_pkg::PRIV_M;
  logic [11:0]        implicit_addr = csb_pkg::ADDR_SUP_SCRATCH;
  csb_pkg::csb_req_s  req;
  csb_pkg::csb_rsp_s  rsp, r;
  csb_pkg::csb_priv_e priv_mode;
  logic [63:0]        next_pc_addr, implicit_rdata, v;
  logic [25:0]        ext_enabled, cur;
  logic [31:0]        lfsr = 32'h61;
  logic               instruction_alignment_width_16, narrow_width, ctrl_write_pulse;
  int                 n_fail = 0;
  int                 comparisons = 0;
  int                 n_pulse, np;

  always #12.5 clk = ~clk;

  csb_csr_bank dut (.clk(clk), .rst(rst), .req(req), .rsp(rsp),
    .next_pc_addr(next_pc_addr), .mode_load(mode_load), .mode_value(mode_value),
    .implicit_addr(implicit_addr), .implicit_rdata(implicit_rdata),
    .priv_mode(priv_mode), .ext_enabled(ext_enabled), .instruction_alignment_width_16(instruction_alignment_width_16),
    .narrow_width(narrow_width), .ctrl_write_pulse(ctrl_write_pulse));

  csb_pipe_model pm (.clk(clk), .req(req), .next_pc_addr(next_pc_addr), .rsp(rsp),
    .ctrl_write_pulse(ctrl_write_pulse), .n_pulse(n_pulse));

  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : nxt

  // Expected extension set after one access to the ISA register
  function automatic logic [25:0] exp_isa(input logic [25:0] c, input logic [1:0] op,
                                         input logic [25:0] d, input logic pc1);
    logic [25:0] x;
    case (op)
      2'h1: x = d;
      2'h2: x = c | d;
      2'h3: x = c & ~d;
      default: x = c;
    endcase
    x = (c & ~csb_pkg::ISA_WRITABLE) | (x & csb_pkg::ISA_WRITABLE);
    x[csb_pkg::EXT_E] = ~x[csb_pkg::EXT_I];
    if (!x[csb_pkg::EXT_F]) x[csb_pkg::EXT_D] = 1'b0;
    if (!x[csb_pkg::EXT_U]) x[csb_pkg::EXT_S] = 1'b0;
    // Losing C on a misaligned next address drops the write
    if (c[csb_pkg::EXT_C] && !x[csb_pkg::EXT_C] && pc1) x = c;
    return x;
  endfunction : exp_isa

  task automatic chk(input string what, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic acc(input logic [1:0] op, input logic [11:0] a, input logic [63:0] d,
                     input logic pc1, input logic ill);
    pm.access(csb_pkg::csb_op_e'(op), a, d, pc1, r);
    chk("valid", 64'h1, r.valid);
    chk("illegal", {63'h0, ill}, r.illegal);
    if (ill) chk("rdata", 64'h0, r.rdata);
  endtask : acc

  task automatic mode(input csb_pkg::csb_priv_e m);
    mode_value = m;
    mode_load = 1'b1;
    @(posedge clk);
    #1;
    mode_load = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : mode

  task automatic test_done;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  // Hang guard
  initial begin
    #2000000;
    n_fail++;
    test_done();
  end

  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    chk("priv", csb_pkg::PRIV_M, priv_mode);
    chk("ext", csb_pkg::ISA_RESET, ext_enabled);
    chk("narrow", 64'h0, narrow_width);
    cur = csb_pkg::ISA_RESET;
    for (int i = 0; i < 24; i++) begin
      lfsr = nxt(lfsr);
      acc(lfsr[31:30], csb_pkg::ADDR_ISA, {lfsr, lfsr}, lfsr[29], 1'b0);
      chk("isa", {csb_pkg::BASE_WIDTH_CODE, 36'h0, cur}, r.rdata);
      cur = exp_isa(cur, lfsr[31:30], lfsr[25:0], lfsr[29]);
      chk("ext", cur, ext_enabled);
      chk("instruction_alignment_width", cur[csb_pkg::EXT_C], instruction_alignment_width_16);
    end
    acc(2'h1, csb_pkg::ADDR_ISA, {38'h0, csb_pkg::ISA_RESET}, 1'b0, 1'b0);
    acc(2'h3, csb_pkg::ADDR_ISA, 64'h4, 1'b1, 1'b0);
    chk("veto", csb_pkg::ISA_RESET, ext_enabled);
    acc(2'h1, csb_pkg::ADDR_EXT_CTRL, 64'h3, 1'b0, 1'b0);
    acc(2'h0, csb_pkg::ADDR_EXT_CTRL, 64'h0, 1'b0, 1'b0);
    chk("fp", 64'h3, r.rdata[1:0]);
    chk("alias", csb_pkg::WIDTH_RESET, r.rdata[5:4]);
    np = n_pulse;
    acc(2'h3, csb_pkg::ADDR_ISA, 64'h20, 1'b0, 1'b0);
    chk("dep", csb_pkg::ISA_RESET & ~26'h28, ext_enabled);
    acc(2'h0, csb_pkg::ADDR_EXT_CTRL, 64'h0, 1'b0, 1'b0);
    chk("fp", 64'h0, r.rdata[1:0]);
    chk("pulse", np, n_pulse);
    lfsr = nxt(lfsr);
    v = {lfsr, ~lfsr};
    acc(2'h1, csb_pkg::ADDR_SUP_SCRATCH, v, 1'b0, 1'b0);
    acc(2'h0, csb_pkg::ADDR_SUP_SCRATCH, 64'h0, 1'b0, 1'b0);
    chk("scratch", v & ~csb_pkg::SCRATCH_RO_MASK, r.rdata);
    chk("pulse", np + 1, n_pulse);
    np = n_pulse;
    acc(2'h1, csb_pkg::ADDR_WIDTH_CTRL, 64'h9, 1'b0, 1'b0);
    acc(2'h0, csb_pkg::ADDR_SUP_SCRATCH, 64'h0, 1'b0, 1'b0);
    v = {32'h0, v[31:0] & 32'hffff_fffc};
    chk("resize", v, r.rdata);
    chk("implicit", v, implicit_rdata);
    chk("pulse", np, n_pulse);
    acc(2'h3, csb_pkg::ADDR_ISA, 64'h40000, 1'b0, 1'b0);
    acc(2'h0, csb_pkg::ADDR_EXT_CTRL, 64'h0, 1'b0, 1'b0);
    chk("alias", 64'h0, r.rdata[5:4]);
    acc(2'h2, csb_pkg::ADDR_ISA, 64'h40000, 1'b0, 1'b0);
    acc(2'h0, csb_pkg::ADDR_EXT_CTRL, 64'h0, 1'b0, 1'b0);
    chk("alias", 64'h1, r.rdata[5:4]);
    acc(2'h3, csb_pkg::ADDR_ISA, 64'h100000, 1'b0, 1'b0);
    mode(csb_pkg::PRIV_U);
    chk("priv", csb_pkg::PRIV_M, priv_mode);
    acc(2'h1, csb_pkg::ADDR_ISA, {38'h0, csb_pkg::ISA_RESET}, 1'b0, 1'b0);
    mode(csb_pkg::PRIV_S);
    chk("priv", csb_pkg::PRIV_S, priv_mode);
    chk("narrow", 64'h1, narrow_width);
    acc(2'h0, csb_pkg::ADDR_ISA, 64'h0, 1'b0, 1'b1);
    lfsr = nxt(lfsr);
    acc(2'h1, csb_pkg::ADDR_EVT_CNT_HI, {32'h0, lfsr}, 1'b0, 1'b0);
    acc(2'h1, csb_pkg::ADDR_EVT_CNT, 64'hffff_ffff_0000_0010, 1'b0, 1'b0);
    acc(2'h0, csb_pkg::ADDR_EVT_CNT, 64'h0, 1'b0, 1'b0);
    chk("cnt_hi", 64'h0, r.rdata[63:32]);
    acc(2'h0, csb_pkg::ADDR_EVT_CNT_HI, 64'h0, 1'b0, 1'b0);
    chk("hi_half", {32'h0, lfsr}, r.rdata);
    mode(csb_pkg::PRIV_M);
    chk("narrow", 64'h0, narrow_width);
    acc(2'h0, csb_pkg::ADDR_EVT_CNT, 64'h0, 1'b0, 1'b0);
    chk("cnt_hi", {32'h0, lfsr}, r.rdata[63:32]);
    chk("cnt_lo", 64'h1, (r.rdata[31:0] - 32'h10) < 32'h40);
    acc(2'h0, csb_pkg::ADDR_EVT_CNT_HI, 64'h0, 1'b0, 1'b1);
    acc(2'h0, 12'h7ff, 64'h0, 1'b0, 1'b1);
    test_done();
  end
endmodule : tb_top
